/* File: common/sfl_cfg.svh */
// Shared constants of the serial flash link, device end and host end
// Assumes inclusion by bare name; the testbench and both ends read it
// Notes on behaviour
// R1 - Protect-from-bottom resets 0, top area protected
// R2 - Protect-from-bottom is config bit 3, one-time settable
// R3 - Dummy select at config bit 6 sets wait cycles; device only stores it, fast read always waits 8 bits
// R4 - Config read answered even while busy
// R5 - Config byte shifts out on serial output only
// R6 - Host polls busy before new commands; host start checks only its own engine idle
// R7 - Register write needs write-enable latch set first
// R8 - Register write data never alters latch or busy bits
// R9 - Select must rise after exactly 16 or 24 bits
// R10 - Select rise starts timed cycle, latch clears after
// R11 - Writes allowed unless disable set and pin low
// R12 - Disable set and pin low rejects register writes
// R13 - Protection ends only when pin goes high
// R14 - Program refused inside block-protected region
// R15 - Host holds protect pin high during write; host drives it from PINS bit 0, reset high
// R16 - Address sampled rising, data driven falling edges
// R17 - Plain read: opcode, 3 address bytes, data
// R18 - Address advances per byte, wraps to zero
// R19 - Fast read adds one dummy byte
// R20 - Fast read rejected while busy, cycle undisturbed
// R21 - Status byte layout, disable bit7 to busy bit0
// R22 - Quad enable disables pin protection
// R23 - Opcodes are design parameters
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH
`define SFL_OP_WRITE_ENABLE_CMD      8'h06
`define SFL_OP_REGISTER_WRITE_CMD      8'h01
`define SFL_OP_RDSR      8'h05
`define SFL_OP_CONFIG_READ_CMD      8'h15
`define SFL_OP_READ      8'h03
`define SFL_OP_FAST      8'h0b
`define SFL_SR_STATUS_WRITE_DISABLE      7
`define SFL_SR_QE        6
`define SFL_SR_BP_LSB    2
`define SFL_CR_DC        6
`define SFL_CR_TB        3
`define SFL_SR_RST       8'h00
`define SFL_CR_RST       8'h00
`define SFL_CLK_NS       40
`define SFL_TW_NS        10000
`define SFL_TW_CYC       ((`SFL_TW_NS + `SFL_CLK_NS - 1) / `SFL_CLK_NS)
`define SFL_TPP_NS       4000
`define SFL_PP_CYC       ((`SFL_TPP_NS + `SFL_CLK_NS - 1) / `SFL_CLK_NS)
`define SFL_BLK_SHIFT    16
`define SFL_ADDR_BITS    24
`define SFL_BITS_OP      6'd8
`define SFL_BITS_ADDR    6'd32
`define SFL_BITS_FAST    6'd40
`define SFL_BITS_WR1     6'd16
`define SFL_BITS_WR2     6'd24
`define SFL_SCK_HALF     4
`define SFL_H_CTRL       8'h00
`define SFL_H_ADDR       8'h04
`define SFL_H_TXD        8'h08
`define SFL_H_RXD        8'h0c
`define SFL_H_STAT       8'h10
`define SFL_H_PINS       8'h14
`define SFL_CT_HASA      8
`define SFL_CT_DUMMY     9
`define SFL_CT_TX_LSB    10
`define SFL_CT_RX_LSB    12
`define SFL_CT_GO        31
`define SFL_PINS_RST     32'h0000_0001
`endif

/* File: common/sfl_pkg.sv */
// Types shared by both ends of the serial flash link
// Assumes sfl_cfg.svh is on the include path
package sfl_pkg;
  typedef enum logic [2:0] {
    SFL_PH_CMD  = 3'h0,
    SFL_PH_ADDR = 3'h1,
    SFL_PH_WR   = 3'h2,
    SFL_PH_OUT  = 3'h3,
    SFL_PH_SKIP = 3'h4
  } sfl_phase_e;
  typedef enum logic [1:0] {
    SFL_SRC_MEM = 2'h0,
    SFL_SRC_SR  = 2'h1,
    SFL_SRC_CR  = 2'h2
  } sfl_src_e;
  typedef enum logic [2:0] {
    SFL_HS_IDLE = 3'h0,
    SFL_HS_LOW  = 3'h1,
    SFL_HS_HIGH = 3'h2,
    SFL_HS_END  = 3'h3,
    SFL_HS_GAP  = 3'h4
  } sfl_hstate_e;
endpackage

/* File: common/sfl_link_if.sv */
// Serial flash link between host controller and flash device
// Serial output idles high when the device does not drive it
interface sfl_link_if;
  logic sclk;
  logic cs_n;
  logic si;
  logic wp_n;
  logic so;
  logic so_oe;
  wire  so_line;
  assign so_line = so_oe ? so : 1'b1;
  modport dev (
    input  sclk,
    input  cs_n,
    input  si,
    input  wp_n,
    output so,
    output so_oe
  );
  modport host (
    output sclk,
    output cs_n,
    output si,
    output wp_n,
    input  so_line
  );
endinterface

/* File: design/sfl_device.sv */
// Serial flash device end: command decode, status and config bytes, reads
// Assumes link pins from another domain; aclk much faster than sclk
`include "sfl_cfg.svh"
module sfl_device #(
  parameter int         ADDR_W  = 19,
  parameter logic [7:0] OP_WRITE_ENABLE_CMD = `SFL_OP_WRITE_ENABLE_CMD,
  parameter logic [7:0] OP_REGISTER_WRITE_CMD = `SFL_OP_REGISTER_WRITE_CMD,
  parameter logic [7:0] OP_RDSR = `SFL_OP_RDSR,
  parameter logic [7:0] OP_CONFIG_READ_CMD = `SFL_OP_CONFIG_READ_CMD,
  parameter logic [7:0] OP_READ = `SFL_OP_READ,
  parameter logic [7:0] OP_FAST = `SFL_OP_FAST,
  parameter int         TW_CYC  = `SFL_TW_CYC,
  parameter int         PP_CYC  = `SFL_PP_CYC
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Serial link
  sfl_link_if.dev                link,
  // Array program port
  input  wire logic              prog_valid,
  input  wire logic [ADDR_W-1:0] prog_addr,
  input  wire logic [7:0]        prog_data,
  output logic                   prog_ready,
  output logic                   prog_refused,
  // Observed register state
  output logic [7:0]             status_byte,
  output logic [7:0]             config_byte
);
  import sfl_pkg::*;

  localparam int MEM_BYTES = 1 << ADDR_W;

  if (ADDR_W < 17 || ADDR_W > `SFL_ADDR_BITS || TW_CYC < 1 || TW_CYC > 65535
      || PP_CYC < 1 || PP_CYC > 65535) begin : g_chk
    $error("sfl_device parameter out of range");
  end

  logic [7:0]        mem [MEM_BYTES];
  logic [2:0]        sck_q;
  logic [2:0]        cs_q;
  logic [1:0]        si_q;
  logic [1:0]        wp_q;
  sfl_phase_e        phase_q;
  sfl_src_e          src_q;
  logic [5:0]        cnt_q;
  logic [31:0]       rx_q;
  logic [7:0]        op_q;
  logic              fast_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]        sh_q;
  logic [2:0]        obit_q;
  logic              so_q;
  logic              status_write_disable_q;
  logic              qe_q;
  logic [3:0]        bp_q;
  logic              wel_q;
  logic              dc_q;
  logic              tb_q;
  logic [15:0]       busy_q;
  logic              refused_q;

  // Protected span grows by powers of two from one block
  function automatic logic prot_hit(input logic [ADDR_W-1:0] a,
                                    input logic [3:0] bp, input logic tb);
    int unsigned span;
    int unsigned ai;
    span = 0;
    ai = 32'(a);
    if (bp != 4'h0) begin
      span = 32'(1) << (32'(bp) + `SFL_BLK_SHIFT - 1);
    end
    if (bp == 4'h0) begin
      prot_hit = 1'b0;
    end else if (span >= MEM_BYTES) begin
      prot_hit = 1'b1;
    end else if (tb) begin
      prot_hit = ai < span;
    end else begin
      prot_hit = ai >= (MEM_BYTES - span);
    end
  endfunction

  // Byte for the output shifter
  function automatic logic [7:0] pick(input sfl_src_e s, input logic [ADDR_W-1:0] a);
    case (s)
      SFL_SRC_SR: pick = status_byte;
      SFL_SRC_CR: pick = config_byte;
      default:    pick = mem[a];
    endcase
  endfunction

  wire              sck_rise  = sck_q[1] & ~sck_q[2];
  wire              sck_fall  = ~sck_q[1] & sck_q[2];
  wire              sel       = ~cs_q[1];
  wire              cs_rise   = cs_q[1] & ~cs_q[2];
  wire              si_s      = si_q[1];
  wire              wp_s      = wp_q[1];
  wire              busy      = busy_q != 16'h0000;
  wire              hardware_protection       = status_write_disable_q & ~wp_s & ~qe_q; // R12 R13 R22
  wire [31:0]       rx_d      = {rx_q[30:0], si_s};
  wire [5:0]        cnt_inc   = (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01;
  wire [7:0]        op_d      = rx_d[7:0];
  wire              at_addr   = cnt_inc == `SFL_BITS_ADDR;
  wire [ADDR_W-1:0] start_a   = at_addr ? rx_d[ADDR_W-1:0] : addr_q;
  wire              addr_done = at_addr & ~fast_q | (cnt_inc == `SFL_BITS_FAST) & fast_q;
  wire              wr_len1   = cnt_q == `SFL_BITS_WR1;
  wire              wr_len2   = cnt_q == `SFL_BITS_WR2;
  wire              wr_go     = cs_rise & (phase_q == SFL_PH_WR) & (wr_len1 | wr_len2)
                                & wel_q & ~busy & ~hardware_protection; // R7 R9 R11 R12
  wire [7:0]        wr_sr     = wr_len2 ? rx_q[15:8] : rx_q[7:0];
  wire              write_enable_cmd_go   = cs_rise & (op_q == OP_WRITE_ENABLE_CMD) & (cnt_q == `SFL_BITS_OP) & ~busy;
  wire              prog_go   = prog_valid & prog_ready;
  wire              prog_ok   = prog_go & wel_q & ~prot_hit(prog_addr, bp_q, tb_q); // R14

  assign status_byte = {status_write_disable_q, qe_q, bp_q, wel_q, busy}; // R21
  assign config_byte = (8'(dc_q) << `SFL_CR_DC) | (8'(tb_q) << `SFL_CR_TB); // R3
  assign prog_ready  = ~busy & ~wr_go;
  assign prog_refused = refused_q;
  assign link.so     = so_q;
  assign link.so_oe  = phase_q == SFL_PH_OUT; // R5

  // Pin synchronisers and edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_q <= 3'h0;
      cs_q  <= 3'h7;
      si_q  <= 2'h0;
      wp_q  <= 2'h3;
    end else begin
      sck_q <= {sck_q[1:0], link.sclk};
      cs_q  <= {cs_q[1:0], link.cs_n};
      si_q  <= {si_q[0], link.si};
      wp_q  <= {wp_q[0], link.wp_n};
    end
  end

  // Command framing and shifting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= SFL_PH_CMD;
      src_q   <= SFL_SRC_MEM;
      cnt_q   <= 6'h00;
      rx_q    <= 32'h0;
      op_q    <= 8'h00;
      fast_q  <= 1'b0;
      addr_q  <= '0;
      sh_q    <= 8'h00;
      obit_q  <= 3'h0;
      so_q    <= 1'b0;
    end else if (!sel) begin
      phase_q <= SFL_PH_CMD;
      cnt_q   <= 6'h00;
      obit_q  <= 3'h0;
    end else if (sck_rise) begin
      rx_q  <= rx_d; // R16
      cnt_q <= cnt_inc;
      case (phase_q)
        SFL_PH_CMD: begin
          if (cnt_inc == `SFL_BITS_OP) begin
            op_q   <= op_d;
            fast_q <= op_d == OP_FAST;
            if (op_d == OP_READ) begin
              phase_q <= SFL_PH_ADDR; // R17
            end else if (op_d == OP_FAST) begin
              phase_q <= busy ? SFL_PH_SKIP : SFL_PH_ADDR; // R19 R20
            end else if (op_d == OP_CONFIG_READ_CMD || op_d == OP_RDSR) begin
              phase_q <= SFL_PH_OUT; // R4
              src_q   <= (op_d == OP_CONFIG_READ_CMD) ? SFL_SRC_CR : SFL_SRC_SR;
              sh_q    <= (op_d == OP_CONFIG_READ_CMD) ? config_byte : status_byte; // R5
            end else if (op_d == OP_REGISTER_WRITE_CMD) begin
              phase_q <= SFL_PH_WR;
            end else begin
              phase_q <= SFL_PH_SKIP;
            end
          end
        end
        SFL_PH_ADDR: begin
          if (at_addr) begin
            addr_q <= rx_d[ADDR_W-1:0];
          end
          if (addr_done) begin
            phase_q <= SFL_PH_OUT; // R17 R19
            src_q   <= SFL_SRC_MEM;
            sh_q    <= mem[start_a];
            addr_q  <= start_a + 1'b1; // R18
          end
        end
        default: begin
        end
      endcase
    end else if (sck_fall && phase_q == SFL_PH_OUT) begin
      so_q   <= sh_q[7]; // R16
      obit_q <= obit_q + 3'h1;
      if (obit_q == 3'h7) begin
        sh_q <= pick(src_q, addr_q);
        if (src_q == SFL_SRC_MEM) begin
          addr_q <= addr_q + 1'b1; // R18
        end
      end else begin
        sh_q <= {sh_q[6:0], 1'b0};
      end
    end
  end

  // Status and configuration bits, timed cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_write_disable_q    <= 1'(`SFL_SR_RST >> `SFL_SR_STATUS_WRITE_DISABLE);
      qe_q      <= 1'b0;
      bp_q      <= 4'h0;
      wel_q     <= 1'b0;
      dc_q      <= 1'(`SFL_CR_RST >> `SFL_CR_DC);
      tb_q      <= 1'b0; // R1
      busy_q    <= 16'h0000;
      refused_q <= 1'b0;
    end else begin
      refused_q <= prog_go & ~prog_ok;
      if (busy_q == 16'h0001 || (prog_go && !prog_ok)) begin
        wel_q <= 1'b0; // R10 R14
      end
      if (write_enable_cmd_go) begin
        wel_q <= 1'b1; // R7
      end
      if (wr_go) begin
        status_write_disable_q <= wr_sr[`SFL_SR_STATUS_WRITE_DISABLE]; // R8 R11
        qe_q   <= wr_sr[`SFL_SR_QE];
        bp_q   <= wr_sr[`SFL_SR_BP_LSB +: 4];
        busy_q <= 16'(TW_CYC); // R10
        if (wr_len2) begin
          dc_q <= rx_q[`SFL_CR_DC]; // R3
          tb_q <= tb_q | rx_q[`SFL_CR_TB]; // R2
        end
      end else if (prog_ok) begin
        busy_q <= 16'(PP_CYC);
      end else if (busy) begin
        busy_q <= busy_q - 16'h0001;
      end
    end
  end

  // Array storage, written only by an accepted program
  always_ff @(posedge aclk) begin
    if (prog_ok) begin
      mem[prog_addr] <= prog_data;
    end
  end
endmodule

/* File: design/sfl_host.sv */
// Host end: AXI4-Lite register slave driving serial flash commands
// Assumes the device samples the link with a clock at least as fast
`include "sfl_cfg.svh"
module sfl_host #(
  parameter int HALF = `SFL_SCK_HALF
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial link
  sfl_link_if.host         link
);
  import sfl_pkg::*;

  if (HALF < 3 || HALF > 255) begin : g_chk
    $error("sfl_host HALF out of range");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction

  sfl_hstate_e st_q;
  logic [31:0] ctrl_q, addr_q, txd_q, rxd_q, pins_q;
  logic [55:0] sr_q;
  logic [6:0]  bits_q;
  logic [7:0]  div_q;
  logic [1:0]  so_q;
  logic        sclk_q, cs_n_q, si_q;
  logic        bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;

  wire        wr_take = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  wire [7:0]  wa      = {s_axi_awaddr[7:2], 2'b00};
  wire [7:0]  ra      = {s_axi_araddr[7:2], 2'b00};
  wire        hit_ctl = wa == `SFL_H_CTRL;
  wire        hit_adr = wa == `SFL_H_ADDR;
  wire        hit_txd = wa == `SFL_H_TXD;
  wire        hit_pin = wa == `SFL_H_PINS;
  wire        wa_ok   = hit_ctl | hit_adr | hit_txd | hit_pin;
  wire [31:0] ctl_new = merge(ctrl_q, s_axi_wdata, s_axi_wstrb);
  wire        idle    = st_q == SFL_HS_IDLE;
  wire        start   = wr_take & hit_ctl & ctl_new[`SFL_CT_GO] & idle; // R6
  wire        has_a   = ctl_new[`SFL_CT_HASA];
  wire        dum     = ctl_new[`SFL_CT_DUMMY]; // R19
  wire [1:0]  ntx     = ctl_new[`SFL_CT_TX_LSB +: 2];
  wire [2:0]  nrx     = ctl_new[`SFL_CT_RX_LSB +: 3];
  wire [6:0]  nbits   = 7'd8 + (has_a ? 7'd24 : 7'd0) + (dum ? 7'd8 : 7'd0)
                        + {2'b00, ntx, 3'b000} + {1'b0, nrx, 3'b000}; // R9 R17
  wire [55:0] frame   = has_a ? {ctl_new[7:0], addr_q[23:0], 24'h000000}
                              : {ctl_new[7:0], txd_q[7:0], txd_q[15:8], 32'h0}; // R17
  wire        ra_ok   = ra <= `SFL_H_PINS;
  wire [31:0] rd_mux  = (ra == `SFL_H_CTRL) ? ctrl_q :
                        (ra == `SFL_H_ADDR) ? addr_q :
                        (ra == `SFL_H_TXD)  ? txd_q  :
                        (ra == `SFL_H_RXD)  ? rxd_q  :
                        (ra == `SFL_H_STAT) ? {31'h0, ~idle} : pins_q;
  wire        div_end = div_q == 8'h00;

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign link.sclk     = sclk_q;
  assign link.cs_n     = cs_n_q;
  assign link.si       = si_q;
  assign link.wp_n     = pins_q[0]; // R15

  // Register slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= 32'h0;
      addr_q   <= 32'h0;
      txd_q    <= 32'h0;
      pins_q   <= `SFL_PINS_RST;
      bvalid_q <= 1'b0;
      bresp_q  <= 2'b00;
      rvalid_q <= 1'b0;
      rresp_q  <= 2'b00;
      rdata_q  <= 32'h0;
    end else begin
      if (wr_take) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wa_ok ? 2'b00 : 2'b10;
        if (hit_ctl && idle) ctrl_q <= ctl_new & 32'h7fff_ffff;
        if (hit_adr) addr_q <= merge(addr_q, s_axi_wdata, s_axi_wstrb) & 32'h00ff_ffff;
        if (hit_txd) txd_q <= merge(txd_q, s_axi_wdata, s_axi_wstrb) & 32'h0000_ffff;
        if (hit_pin) pins_q <= merge(pins_q, s_axi_wdata, s_axi_wstrb) & 32'h0000_0001;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rresp_q  <= ra_ok ? 2'b00 : 2'b10;
        rdata_q  <= ra_ok ? rd_mux : 32'h0;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Serial engine, mode 0: drive on falling, sample before falling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= SFL_HS_IDLE;
      sr_q   <= 56'h0;
      bits_q <= 7'h00;
      div_q  <= 8'h00;
      so_q   <= 2'h3;
      rxd_q  <= 32'h0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      si_q   <= 1'b0;
    end else begin
      so_q  <= {so_q[0], link.so_line};
      div_q <= div_end ? 8'h00 : div_q - 8'h01;
      case (st_q)
        SFL_HS_IDLE: begin
          if (start) begin
            cs_n_q <= 1'b0;
            sr_q   <= frame;
            si_q   <= ctl_new[7];
            bits_q <= nbits;
            div_q  <= 8'(HALF - 1);
            st_q   <= SFL_HS_LOW;
          end
        end
        SFL_HS_LOW: begin
          if (div_end) begin
            sclk_q <= 1'b1;
            div_q  <= 8'(HALF - 1);
            st_q   <= SFL_HS_HIGH;
          end
        end
        SFL_HS_HIGH: begin
          if (div_end) begin
            rxd_q  <= {rxd_q[30:0], so_q[1]};
            sclk_q <= 1'b0;
            bits_q <= bits_q - 7'h01;
            sr_q   <= {sr_q[54:0], 1'b0};
            si_q   <= sr_q[54];
            div_q  <= 8'(HALF - 1);
            st_q   <= (bits_q == 7'h01) ? SFL_HS_END : SFL_HS_LOW;
          end
        end
        SFL_HS_END: begin
          if (div_end) begin
            cs_n_q <= 1'b1; // R9
            div_q  <= 8'(HALF - 1);
            st_q   <= SFL_HS_GAP;
          end
        end
        SFL_HS_GAP: begin
          if (div_end) begin
            st_q <= SFL_HS_IDLE;
          end
        end
        default: begin
          st_q <= SFL_HS_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: verification/sfl_checker.sv */
// Concurrent checks on the serial flash link between host and device ends
// Assumes the host runs its default divider: sclk high and low 4 aclk each
module sfl_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic so_line
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_si_steady;
    sclk && $past(sclk) |-> $stable(si);
  endproperty
  a_si_steady: assert property (p_si_steady) else $error("si moved while sclk high");

  property p_so_steady;
    sclk && $past(sclk) && so_oe && $past(so_oe) |-> $stable(so);
  endproperty
  a_so_steady: assert property (p_so_steady) else $error("so moved while sclk high");

  property p_sclk_high;
    $rose(sclk) |-> sclk [*4] ##1 !sclk;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("sclk high phase wrong");

  property p_oe_in_frame;
    $rose(so_oe) |-> !cs_n;
  endproperty
  a_oe_in_frame: assert property (p_oe_in_frame) else $error("so driven outside frame");

  property p_oe_release;
    cs_n [*6] |-> !so_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("so still driven");

  property p_select_edges;
    $fell(cs_n) || $rose(cs_n) |-> !sclk;
  endproperty
  a_select_edges: assert property (p_select_edges) else $error("select edge with sclk high");

  property p_select_gap;
    $rose(cs_n) |-> cs_n [*3];
  endproperty
  a_select_gap: assert property (p_select_gap) else $error("select gap too short");

  property p_sclk_still;
    cs_n |-> !sclk;
  endproperty
  a_sclk_still: assert property (p_sclk_still) else $error("sclk runs outside frame");

  property p_line_level;
    cs_n && $past(cs_n) && !$past(so_oe) |-> !so_oe;
  endproperty
  a_line_level: assert property (p_line_level) else $error("so enabled while deselected");
endmodule

/* File: verification/test_serial_flash_reg_write_and_read.sv */
// Bench: host end driven over AXI4-Lite, device end across the link
// Assumes sfl_cfg.svh on the include path and default host divider
`include "sfl_cfg.svh"
module test_serial_flash_reg_write_and_read;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr, prog_data, status_byte, config_byte;
  logic [31:0] wdata, rdata, rx;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        prog_valid, prog_ready, prog_refused;
  logic [18:0] prog_addr;
  int          bad_count, checks;

  sfl_link_if link();
  sfl_device #(.ADDR_W(19), .TW_CYC(400), .PP_CYC(10)) i_sfl_device (
    .aclk(aclk), .aresetn(aresetn), .link(link), .prog_valid(prog_valid),
    .prog_addr(prog_addr), .prog_data(prog_data), .prog_ready(prog_ready),
    .prog_refused(prog_refused), .status_byte(status_byte), .config_byte(config_byte));
  sfl_host i_sfl_host (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(link));
  sfl_checker i_sfl_checker (
    .aclk(aclk), .aresetn(aresetn), .sclk(link.sclk), .cs_n(link.cs_n), .si(link.si),
    .so(link.so), .so_oe(link.so_oe), .so_line(link.so_line));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(negedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(negedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // Flags: receive count, send count, dummy byte, address bytes
  task automatic cmd(input logic [7:0] op, input logic [6:0] fl, input logic [23:0] a,
                     input logic [15:0] tx);
    logic [31:0] s;
    axi_wr(`SFL_H_ADDR, {8'h00, a});
    axi_wr(`SFL_H_TXD, {16'h0000, tx});
    axi_wr(`SFL_H_CTRL, {1'b1, 16'h0000, fl, op});
    do axi_rd(`SFL_H_STAT, s); while (s[0] !== 1'b0);
    axi_rd(`SFL_H_RXD, rx);
  endtask

  task automatic wait_idle();
    do @(negedge aclk); while (status_byte[0] !== 1'b0);
    @(posedge aclk);
  endtask

  task automatic prog(input logic [18:0] a, input logic [7:0] d, input logic refuse);
    prog_addr <= a;
    prog_data <= d;
    prog_valid <= 1'b1;
    do @(negedge aclk); while (prog_ready !== 1'b1);
    @(posedge aclk);
    prog_valid <= 1'b0;
    @(negedge aclk);
    chk(prog_refused, refuse);
    wait_idle();
  endtask

  task automatic t_reset();
    chk(status_byte, 8'h00);
    chk(config_byte, 8'h00);
    cmd(`SFL_OP_CONFIG_READ_CMD, 7'h10, 24'h0, 16'h0);
    chk(rx[7:0], 8'h00);
    axi_wr(8'h40, 32'h0);
    chk(resp, 2'b10);
    axi_rd(8'h18, rx);
    chk(resp, 2'b10);
  endtask

  task automatic t_write();
    cmd(`SFL_OP_REGISTER_WRITE_CMD, 7'h08, 24'h0, 16'h48bf);
    chk(status_byte, 8'h00);
    cmd(`SFL_OP_WRITE_ENABLE_CMD, 7'h00, 24'h0, 16'h0);
    chk(status_byte, 8'h02);
    cmd(`SFL_OP_REGISTER_WRITE_CMD, 7'h08, 24'h0, 16'h48bf);
    chk(status_byte[0], 1'b1);
    cmd(`SFL_OP_CONFIG_READ_CMD, 7'h10, 24'h0, 16'h0);
    chk(rx[7:0], 8'h48);
    cmd(`SFL_OP_FAST, 7'h13, 24'h0, 16'h0);
    chk(rx[7:0], 8'hff);
    wait_idle();
    chk(status_byte, 8'hbc);
    chk(config_byte, 8'h48);
  endtask

  task automatic t_protect();
    axi_wr(`SFL_H_PINS, 32'h0);
    cmd(`SFL_OP_WRITE_ENABLE_CMD, 7'h00, 24'h0, 16'h0);
    cmd(`SFL_OP_REGISTER_WRITE_CMD, 7'h08, 24'h0, 16'h0000);
    wait_idle();
    chk(status_byte, 8'hbe);
    axi_wr(`SFL_H_PINS, 32'h1);
    cmd(`SFL_OP_REGISTER_WRITE_CMD, 7'h08, 24'h0, 16'h0000);
    wait_idle();
    chk(status_byte, 8'h00);
    chk(config_byte, 8'h08);
    cmd(`SFL_OP_WRITE_ENABLE_CMD, 7'h00, 24'h0, 16'h0);
    cmd(`SFL_OP_REGISTER_WRITE_CMD, 7'h00, 24'h0, 16'h0);
    chk(status_byte, 8'h02);
  endtask

  task automatic t_read();
    prog(19'h7ffff, 8'ha5, 1'b0);
    cmd(`SFL_OP_WRITE_ENABLE_CMD, 7'h00, 24'h0, 16'h0);
    prog(19'h00000, 8'h5a, 1'b0);
    cmd(`SFL_OP_READ, 7'h21, 24'h07ffff, 16'h0);
    chk(rx[15:0], 16'ha55a);
    cmd(`SFL_OP_FAST, 7'h23, 24'h07ffff, 16'h0);
    chk(rx[15:0], 16'ha55a);
    cmd(`SFL_OP_WRITE_ENABLE_CMD, 7'h00, 24'h0, 16'h0);
    cmd(`SFL_OP_REGISTER_WRITE_CMD, 7'h04, 24'h0, 16'h0004);
    wait_idle();
    cmd(`SFL_OP_WRITE_ENABLE_CMD, 7'h00, 24'h0, 16'h0);
    prog(19'h00000, 8'h00, 1'b1);
    chk(status_byte, 8'h04);
  endtask

  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {prog_valid, prog_addr, prog_data} = '0;
    bad_count = 0;
    checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_reset();
    t_write();
    t_protect();
    t_read();
    wrap_up();
  end

  initial begin
    #2400000;
    bad_count++;
    wrap_up();
  end
endmodule
